// ### inc/vglc_consts.svh
// Register offsets, field positions, default values and counts for the genlock loop control
`ifndef VGLC_CONSTS_SVH
`define VGLC_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define VGLC_ADDR_LOOP_CONST 8'h24
`define VGLC_ADDR_RESERVED_SLOT 8'h25
`define VGLC_ADDR_BW_CAP 8'h26
`define VGLC_ADDR_BW_RES 8'h27
`define VGLC_ADDR_STD 8'h30
`define VGLC_ADDR_STATUS 8'h31
`define VGLC_ADDR_MASK 8'h32
`define VGLC_ADDR_STATE 8'h33

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VGLC_CRASH_MSB 15
`define VGLC_CRASH_LSB 8
`define VGLC_THR_MSB 7
`define VGLC_THR_LSB 3
`define VGLC_WIN_MSB 2
`define VGLC_WIN_LSB 0
`define VGLC_BW_MSB 5
`define VGLC_STD_MSB 1
`define VGLC_EV_LOCK 0
`define VGLC_EV_LOST 1
`define VGLC_EV_MISS 2
`define VGLC_EV_W 3

// ----------------------------------------------------------------
// Per-standard defaults: crash, threshold, window, cap, res
// ----------------------------------------------------------------
`define VGLC_D0 {8'h10, 5'h04, 3'h1, 6'h0C, 6'h24}
`define VGLC_D1 {8'h20, 5'h08, 3'h1, 6'h0E, 6'h26}
`define VGLC_D2 {8'h30, 5'h0C, 3'h2, 6'h0A, 6'h20}
`define VGLC_D3 {8'h40, 5'h10, 3'h2, 6'h10, 6'h2A}

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VGLC_PERIOD_CNT_W 16
`define VGLC_MARGIN_SHIFT 3

`endif

// ### inc/vglc_pkg.sv
// Types and default lookup for the genlock loop control block
`default_nettype none
`include "vglc_consts.svh"

package vglc_pkg;

  // Loop lock sequence states
  typedef enum logic [1:0] {
    VGLC_IDLE,
    VGLC_CRASH,
    VGLC_TRACK
  } vglc_state_t;

  // One set of loop settings
  typedef struct packed {
    logic [7:0] crash;
    logic [4:0] thr;
    logic [2:0] win;
    logic [5:0] cap;
    logic [5:0] res;
  } vglc_defaults_t;

  // Loop settings belonging to an output video standard
  function automatic vglc_defaults_t vglc_std_defaults(input logic [1:0] std);
    vglc_defaults_t d;
    d = `VGLC_D0;
    case (std)
      2'h1: d = `VGLC_D1;
      2'h2: d = `VGLC_D2;
      2'h3: d = `VGLC_D3;
      default: d = `VGLC_D0;
    endcase
    return d;
  endfunction

endpackage

`default_nettype wire

// ### verilog/vglc_top.sv
// Video genlock loop control: settings registers, crash and lock sequencing, pulse tolerance
//
// Strobed register access is this design's own decision.
`default_nettype none
`include "vglc_consts.svh"

module vglc_top #(
  parameter int CNT_W = `VGLC_PERIOD_CNT_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic href_pin,
  output logic [5:0] loop_cap,
  output logic [5:0] loop_res,
  output logic crash_active,
  output logic lock_lost,
  output logic freq_hold,
  output logic irq
);
  import vglc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam vglc_defaults_t RST_DEF = vglc_std_defaults(2'h0);

  logic [7:0] crash_time;
  logic [4:0] lock_thr;
  logic [2:0] run_window;
  logic [1:0] vid_std;
  logic [1:0] std_applied;
  logic [`VGLC_EV_W-1:0] irq_status;
  logic [`VGLC_EV_W-1:0] irq_mask;
  logic [7:0] next_crash_time;
  logic [4:0] next_lock_thr;
  logic [2:0] next_run_window;
  logic [5:0] next_loop_cap;
  logic [5:0] next_loop_res;
  logic [1:0] next_vid_std;
  logic [1:0] next_std_applied;
  logic [`VGLC_EV_W-1:0] next_irq_status;
  logic [`VGLC_EV_W-1:0] next_irq_mask;
  logic [15:0] next_reg_rdata;
  logic next_irq;
  vglc_defaults_t std_def;

  logic [2:0] href_sync;
  logic href_lvl;
  vglc_state_t state;
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] expected;
  logic [9:0] crash_cnt;
  logic [4:0] good_cnt;
  logic [2:0] miss_cnt;
  logic [2:0] next_href_sync;
  logic next_href_lvl;
  vglc_state_t next_state;
  logic [CNT_W-1:0] next_per_cnt;
  logic [CNT_W-1:0] next_expected;
  logic [9:0] next_crash_cnt;
  logic [4:0] next_good_cnt;
  logic [2:0] next_miss_cnt;
  logic next_crash_active;
  logic next_lock_lost;
  logic next_freq_hold;
  logic href_rise;
  logic [CNT_W-1:0] margin;
  logic [CNT_W:0] late_limit;
  logic [9:0] crash_len;
  logic [`VGLC_EV_W-1:0] events;

  // ----------------------------------------------------------------
  // Reference sampling and lock sequencing
  // ----------------------------------------------------------------

  // Three-stage sampler; level moves only when stages two and three agree
  always_comb begin
    next_href_sync = {href_sync[1:0], href_pin};
    next_href_lvl = href_lvl;
    if (href_sync[1] == href_sync[2]) begin
      next_href_lvl = href_sync[2];
    end
    href_rise = next_href_lvl & ~href_lvl;
    margin = expected >> `VGLC_MARGIN_SHIFT;
    late_limit = {1'b0, expected} + {1'b0, margin};
    crash_len = {crash_time, 2'b00} + 10'h001;
    next_state = state;
    next_per_cnt = (per_cnt == {CNT_W{1'b1}}) ? per_cnt : per_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    next_expected = expected;
    next_crash_cnt = crash_cnt;
    next_good_cnt = good_cnt;
    next_miss_cnt = miss_cnt;
    next_crash_active = crash_active;
    next_lock_lost = lock_lost;
    next_freq_hold = freq_hold;
    events = '0;
    unique case (state)
      VGLC_IDLE: begin
        // Wait for the reference to appear, then start a crash lock
        next_lock_lost = 1'b1;
        next_freq_hold = 1'b0;
        if (href_rise) begin
          next_state = VGLC_CRASH;
          next_per_cnt = '0;
          next_crash_cnt = '0;
          next_crash_active = 1'b1;
        end
      end
      VGLC_CRASH: begin
        // Counter saturation means the reference has gone away
        if (per_cnt == {CNT_W{1'b1}}) begin
          next_state = VGLC_IDLE;
          next_crash_active = 1'b0;
        end else if (href_rise) begin
          next_expected = per_cnt;
          next_per_cnt = '0;
          next_crash_cnt = crash_cnt + 10'h001;
          if (next_crash_cnt == crash_len) begin
            next_state = VGLC_TRACK;
            next_crash_active = 1'b0;
            next_good_cnt = '0;
            next_miss_cnt = '0;
          end
        end
      end
      VGLC_TRACK: begin
        if (href_rise && per_cnt >= expected - margin) begin
          // Edge on time: track the period and count toward the lock flag
          next_per_cnt = '0;
          next_expected = per_cnt;
          next_miss_cnt = '0;
          next_freq_hold = 1'b0;
          if (lock_lost && good_cnt >= lock_thr) begin
            next_lock_lost = 1'b0;
            events[`VGLC_EV_LOCK] = 1'b1;
          end else if (good_cnt != 5'h1F) begin
            next_good_cnt = good_cnt + 5'h01;
          end
        end else if (href_rise || {1'b0, per_cnt} == late_limit || &per_cnt) begin
          // Early edge or missing edge: freewheel within the window
          // A saturated count also ends the period, so a wide expectation cannot hang
          events[`VGLC_EV_MISS] = 1'b1;
          next_per_cnt = '0;
          next_good_cnt = '0;
          if (miss_cnt >= run_window) begin
            next_state = VGLC_CRASH;
            next_crash_cnt = '0;
            next_crash_active = 1'b1;
            next_miss_cnt = '0;
            next_freq_hold = 1'b0;
            next_lock_lost = 1'b1;
            events[`VGLC_EV_LOST] = ~lock_lost;
          end else begin
            next_miss_cnt = miss_cnt + 3'h1;
            next_freq_hold = 1'b1;
          end
        end
      end
    endcase
  end

  // Lock sequencing registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      href_sync <= 3'h0;
      href_lvl <= 1'b0;
      state <= VGLC_IDLE;
      per_cnt <= '0;
      expected <= '0;
      crash_cnt <= 10'h000;
      good_cnt <= 5'h00;
      miss_cnt <= 3'h0;
      crash_active <= 1'b0;
      lock_lost <= 1'b1;
      freq_hold <= 1'b0;
    end else begin
      href_sync <= next_href_sync;
      href_lvl <= next_href_lvl;
      state <= next_state;
      per_cnt <= next_per_cnt;
      expected <= next_expected;
      crash_cnt <= next_crash_cnt;
      good_cnt <= next_good_cnt;
      miss_cnt <= next_miss_cnt;
      crash_active <= next_crash_active;
      lock_lost <= next_lock_lost;
      freq_hold <= next_freq_hold;
    end
  end

  // ----------------------------------------------------------------
  // Register port, standard defaults and interrupt
  // ----------------------------------------------------------------

  // Standard change reloads first; a write in the same cycle still wins
  always_comb begin
    std_def = vglc_std_defaults(vid_std);
    next_crash_time = crash_time;
    next_lock_thr = lock_thr;
    next_run_window = run_window;
    next_loop_cap = loop_cap;
    next_loop_res = loop_res;
    next_vid_std = vid_std;
    next_std_applied = std_applied;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_reg_rdata = 16'h0000;
    if (vid_std != std_applied) begin
      next_std_applied = vid_std;
      next_crash_time = std_def.crash;
      next_lock_thr = std_def.thr;
      next_run_window = std_def.win;
      next_loop_cap = std_def.cap;
      next_loop_res = std_def.res;
    end
    // Register writes; unmapped and reserved offsets are ignored
    if (reg_wr) begin
      case (reg_addr)
        `VGLC_ADDR_LOOP_CONST: begin
          next_crash_time = reg_wdata[`VGLC_CRASH_MSB:`VGLC_CRASH_LSB];
          next_lock_thr = reg_wdata[`VGLC_THR_MSB:`VGLC_THR_LSB];
          next_run_window = reg_wdata[`VGLC_WIN_MSB:`VGLC_WIN_LSB];
        end
        // Range limits are software's duty; upper bits are dropped
        `VGLC_ADDR_BW_CAP: next_loop_cap = reg_wdata[`VGLC_BW_MSB:0];
        `VGLC_ADDR_BW_RES: next_loop_res = reg_wdata[`VGLC_BW_MSB:0];
        `VGLC_ADDR_STD: next_vid_std = reg_wdata[`VGLC_STD_MSB:0];
        `VGLC_ADDR_MASK: next_irq_mask = reg_wdata[`VGLC_EV_W-1:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    // Reads answer one cycle later; a status read clears the status
    if (reg_rd) begin
      case (reg_addr)
        `VGLC_ADDR_LOOP_CONST: next_reg_rdata = {crash_time, lock_thr, run_window};
        `VGLC_ADDR_BW_CAP: next_reg_rdata = {10'h000, loop_cap};
        `VGLC_ADDR_BW_RES: next_reg_rdata = {10'h000, loop_res};
        `VGLC_ADDR_STD: next_reg_rdata = {14'h0000, vid_std};
        `VGLC_ADDR_STATUS: begin
          next_reg_rdata = {13'h0000, irq_status};
          next_irq_status = '0;
        end
        `VGLC_ADDR_MASK: next_reg_rdata = {13'h0000, irq_mask};
        // Sequencer view: state, miss count, good count and the three flags
        `VGLC_ADDR_STATE: next_reg_rdata = {3'h0, state, miss_cnt, good_cnt,
                                            freq_hold, crash_active, lock_lost};
        default: next_reg_rdata = 16'h0000;
      endcase
    end
    // Set wins over the read-clear so no event is lost
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // Register port registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      crash_time <= RST_DEF.crash;
      lock_thr <= RST_DEF.thr;
      run_window <= RST_DEF.win;
      loop_cap <= RST_DEF.cap;
      loop_res <= RST_DEF.res;
      vid_std <= 2'h0;
      std_applied <= 2'h0;
      irq_status <= '0;
      irq_mask <= '0;
      reg_rdata <= 16'h0000;
      irq <= 1'b0;
    end else begin
      crash_time <= next_crash_time;
      lock_thr <= next_lock_thr;
      run_window <= next_run_window;
      loop_cap <= next_loop_cap;
      loop_res <= next_loop_res;
      vid_std <= next_vid_std;
      std_applied <= next_std_applied;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      reg_rdata <= next_reg_rdata;
      irq <= next_irq;
    end
  end

endmodule

`default_nettype wire

// ### verif/vglc_assertions.sv
// Port checker for the genlock loop control
`default_nettype none
module vglc_checker #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [5:0] loop_cap,
  input wire logic [5:0] loop_res,
  input wire logic crash_active,
  input wire logic lock_lost,
  input wire logic freq_hold,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Relations
  // ------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_cap_write: assert property (reg_wr && reg_addr == 8'h26 |=>
    loop_cap == $past(reg_wdata[5:0])) else $error("cap not loaded");
  a_res_write: assert property (reg_wr && reg_addr == 8'h27 |=>
    loop_res == $past(reg_wdata[5:0])) else $error("res not loaded");
  a_crash_exit: assert property ($fell(crash_active) |-> lock_lost)
    else $error("lock shown at crash end");
  a_crash_lost: assert property (crash_active |-> lock_lost)
    else $error("lock shown in crash");
  a_lock_fall: assert property ($fell(lock_lost) |->
    !crash_active && !$past(crash_active)) else $error("lock from crash");
  a_hold_excl: assert property (freq_hold |-> !crash_active)
    else $error("hold during crash");
  a_irq_mask: assert property (reg_wr && reg_addr == 8'h32 &&
    reg_wdata == 16'h0000 |=> !irq) else $error("irq while masked");
  // Main scenarios reached
  cover property ($fell(crash_active));
  cover property ($fell(lock_lost));
  cover property ($rose(freq_hold));
endmodule
bind vglc_top vglc_checker #(.CNT_W(CNT_W)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_cap(loop_cap),
  .loop_res(loop_res), .crash_active(crash_active), .lock_lost(lock_lost),
  .freq_hold(freq_hold), .irq(irq));
`default_nettype wire

// ### verif/vglc_href_src.sv
// Model of the incoming H reference pulse train
`default_nettype none
module vglc_href_src (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic skip,
  input wire logic [7:0] period,
  output logic href
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  logic drop = 1'b0;
  // Period counter; a skip seen just before a pulse removes that one pulse
  always_ff @(posedge ref_clk) begin
    cnt <= (!run || cnt == period - 8'h01) ? 8'h00 : cnt + 8'h01;
    if (cnt == period - 8'h01) drop <= skip;
  end
  // Pulse 4 cycles wide so the input filter sees it; line idles low
  assign href = run && !drop && cnt < 8'h04;
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the genlock loop control
`default_nettype none
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
`define WT(c) begin \
  to = 0; \
  while (!(c) && to < 6000) begin \
    @(posedge ref_clk); \
    to++; \
  end \
  #1; \
  if (!(c)) begin \
    miscompares++; \
    report_and_stop(); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic skip = 1'b0;
  logic hp = 1'b0;
  logic fh = 1'b0;
  logic [15:0] reg_rdata;
  logic [5:0] loop_cap, loop_res;
  logic crash_active, lock_lost, freq_hold, irq, href_pin;
  int miscompares = 0;
  int cmp_count = 0;
  int nc = 0;
  int nr = 0;
  int to, snap, i;
  // Expected settings per standard: word at 0x24 and {cap, res}
  logic [15:0] d24 [4] = '{16'h1021, 16'h2041, 16'h3062, 16'h4082};
  logic [11:0] dbw [4] = '{12'h324, 12'h3A6, 12'h2A0, 12'h42A};

  vglc_top #(.CNT_W(8)) dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .href_pin(href_pin), .loop_cap(loop_cap), .loop_res(loop_res),
    .crash_active(crash_active), .lock_lost(lock_lost), .freq_hold(freq_hold), .irq(irq));
  vglc_href_src u_src (.ref_clk(ref_clk), .run(run), .skip(skip), .period(8'h20),
    .href(href_pin));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // Count all reference rises, and apart from them those inside the crash phase
  always @(posedge ref_clk) begin
    hp <= href_pin;
    if (freq_hold) fh <= 1'b1;
    if (href_pin && !hp) begin
      nr <= nr + 1;
      if (crash_active) nc <= nc + 1;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read strobe for one cycle; data only stands in the next one
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // Remove exactly one pulse: skip spans one period
  task automatic drop_one;
    @(posedge ref_clk);
    skip <= 1'b1;
    repeat (32) @(posedge ref_clk);
    skip <= 1'b0;
  endtask
  task report_and_stop;
    $display("Compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    `CHK({loop_cap, loop_res}, dbw[0])
    rc(8'h24, d24[0]);
    rc(8'h25, 16'h0000);
    rc(8'h40, 16'h0000);
    wr(8'h32, 16'h0000);
    // Each standard reloads its own set
    for (i = 1; i < 5; i++) begin
      wr(8'h30, 16'(i % 4));
      rc(8'h24, d24[i % 4]);
      `CHK({loop_cap, loop_res}, dbw[i % 4])
    end
    wr(8'h27, 16'h0020);
    wr(8'h26, 16'h000B);
    rc(8'h26, 16'h000B);
    `CHK({loop_cap, loop_res}, 12'h2E0)
    // Short crash of 5 periods, lock after 3 good edges
    wr(8'h24, 16'h0111);
    wr(8'h32, 16'h0007);
    run <= 1'b1;
    `WT(crash_active)
    `WT(!crash_active)
    snap = nr;
    `CHK(nc, 5)
    `WT(!lock_lost)
    `CHK(nr - snap, 3)
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(irq, 1'b1)
    rc(8'h31, 16'h0001);
    `CHK(irq, 1'b0)
    // One lost pulse is ridden out at window 1
    drop_one();
    repeat (64) @(posedge ref_clk);
    #1;
    `CHK({fh, lock_lost, crash_active}, 3'b100)
    rc(8'h31, 16'h0004);
    // Window 0 restarts the crash at once; mask keeps irq low
    wr(8'h24, 16'h0110);
    wr(8'h32, 16'h0000);
    drop_one();
    `WT(crash_active)
    `CHK({lock_lost, irq}, 2'b10)
    rc(8'h31, 16'h0006);
    // Restarted crash: state 1, counts cleared, crash and lost flags up
    rc(8'h33, 16'h0803);
    report_and_stop();
  end
endmodule
`default_nettype wire
